// [edo_dram_host.sv]
`timescale 1ns/1ps
// How it works
// - wait 100us, then eight wake refreshes
// - repeat wake-up after refresh period overrun
// - row-only refresh covers all rows
// - 4096 column-before-row refreshes per 64 ms
// - self-refresh part may stretch to 128 ms
// - row low 100us enters self refresh
// - row high exit precharge after self refresh
// - pulse column high to start new cycle
// - hold read command past strobe rise
// - delay write for read-modify-write
// - never late write with output enable tied
// - hidden refresh after write allowed
// - write low pulse disables outputs
// - page row low below 125 us
// - column held low during self refresh entry
module edo_dram_host
#(
    parameter int POWERUP_CYCLES = dram_ctl_pkg::POWERUP_CYC,
    parameter int SELF_LOW_CYCLES = dram_ctl_pkg::SELF_LOW_CYC,
    // 64 ms pace also meets stretched period
    parameter int REFRESH_INTERVAL = dram_ctl_pkg::REF_INT_CYC,
    parameter bit SELF_REFRESH_PART = 1'b0
) (
    // clock and reset
    input  wire logic                          CLOCK,
    input  wire logic                          RST,
    // user request, read data and self refresh status
    input  wire logic                          REQ_VALID,
    output logic                               REQ_READY,
    input  wire logic [1:0]                    REQ_OP,
    input  wire logic [dram_ctl_pkg::ROW_W-1:0] REQ_ROW,
    input  wire logic [dram_ctl_pkg::ROW_W-1:0] REQ_COL,
    input  wire logic [dram_ctl_pkg::DQ_W-1:0]  REQ_WDATA,
    input  wire logic                          SELF_REQ,
    output logic                               RDATA_VALID,
    output logic [dram_ctl_pkg::DQ_W-1:0]      RDATA,
    output logic                               IN_SELF,
    // dram pins, strobes active low
    output logic                               RAS_N,
    output logic                               CAS_N,
    output logic                               WE_N,
    output logic                               OE_N,
    output logic [dram_ctl_pkg::ROW_W-1:0]     ADDR,
    input  wire logic [dram_ctl_pkg::DQ_W-1:0]  DQ_IN,
    output logic [dram_ctl_pkg::DQ_W-1:0]      DQ_OUT,
    output logic                               DQ_OE
);
    import dram_ctl_pkg::*;

    // elaboration checks; an interval shorter than one access would starve requests
    if (POWERUP_CYCLES < 1 || SELF_LOW_CYCLES < 1 || REFRESH_INTERVAL < 64)
        $error("edo_dram_host: timing parameter out of range");
    if (POWERUP_CYCLES >= (1 << CNT_W) || SELF_LOW_CYCLES >= (1 << CNT_W) || REFRESH_INTERVAL >= (1 << CNT_W))
        $error("edo_dram_host: count too wide");

    state_e state;
    logic [CNT_W-1:0] timer;
    logic [CNT_W-1:0] ref_timer;
    logic [3:0]       wake_left;
    logic             ref_due;
    logic             ref_overrun;
    logic [1:0]       op;
    logic [ROW_W-1:0] col;
    logic             in_self_pend;

    // timer expiry ends each timed step; the pending refresh and self request hold off a take in idle
    wire timer_done  = (timer == '0);
    wire take_req    = (state == S_IDLE) && !ref_due && REQ_VALID && !SELF_REQ;
    assign REQ_READY = take_req;

    // refresh interval timer; an interval missed twice means the period was blown
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ref_timer   <= '0;
            ref_due     <= 1'b0;
            ref_overrun <= 1'b0;
        end else if (state == S_POWERUP || state == S_SELF) begin
            // wake-up or self refresh starts the period afresh
            ref_timer   <= '0;
            ref_due     <= 1'b0;
            ref_overrun <= 1'b0;
        end else if (ref_timer == CNT_W'(REFRESH_INTERVAL - 1)) begin
            ref_timer <= '0;
            ref_due   <= 1'b1;
            if (ref_due)
                ref_overrun <= 1'b1;
        end else begin
            ref_timer <= ref_timer + 1'b1;
            if (state == S_REF_CAS)
                ref_due <= 1'b0;
        end
    end

    // main cycle sequencer; every minimum is a rounded-up cycle count
    // counts from package
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state <= S_POWERUP;
            timer <= CNT_W'(POWERUP_CYCLES);
            wake_left <= 4'(WAKE_CYCLES);
            RAS_N <= 1'b1;
            CAS_N <= 1'b1;
            WE_N  <= 1'b1;
            OE_N  <= 1'b1;
            ADDR  <= '0;
            DQ_OUT <= '0;
            DQ_OE <= 1'b0;
            RDATA <= '0;
            RDATA_VALID <= 1'b0;
            op <= OP_READ;
            col <= '0;
            in_self_pend <= 1'b0;
        end else begin
            RDATA_VALID <= 1'b0;
            if (!timer_done)
                timer <= timer - 1'b1;
            case (state)
                S_POWERUP: begin
                    if (timer_done) begin
                        state <= S_REF_CAS;
                        CAS_N <= 1'b0;
                        WE_N  <= 1'b1;
                        timer <= CNT_W'(CSR_CYC);
                    end
                end
                S_IDLE: begin
                    if (ref_overrun) begin
                        wake_left <= 4'(WAKE_CYCLES);
                        state <= S_POWERUP;
                        timer <= '0;
                    end else if (ref_due || SELF_REQ) begin
                        // no hidden refresh, strobes idle first
                        state <= S_REF_CAS;
                        CAS_N <= 1'b0;
                        WE_N  <= 1'b1;
                        in_self_pend <= SELF_REQ && !ref_due;
                        timer <= CNT_W'(CSR_CYC);
                    end else if (take_req) begin
                        op <= REQ_OP;
                        col <= REQ_COL;
                        ADDR <= REQ_ROW;
                        RAS_N <= 1'b0;
                        DQ_OUT <= REQ_WDATA;
                        WE_N <= (REQ_OP != OP_WRITE);
                        OE_N <= 1'b1;
                        state <= S_ROW;
                        timer <= CNT_W'(RCD_CYC);
                    end
                end
                // one column per row, no page
                S_ROW: begin
                    if (timer_done) begin
                        ADDR <= col;
                        CAS_N <= 1'b0;
                        DQ_OE <= (op == OP_WRITE);
                        OE_N <= (op == OP_WRITE);
                        state <= S_COL;
                        timer <= CNT_W'(op == OP_RMW ? ROW_WRITE_CYC - RCD_CYC : CAC_CYC);
                    end
                end
                S_COL: begin
                    if (timer_done) begin
                        if (op == OP_READ || op == OP_RMW) begin
                            RDATA <= DQ_IN;
                            RDATA_VALID <= 1'b1;
                        end
                        if (op == OP_RMW) begin
                            OE_N <= 1'b1;
                            WE_N <= 1'b0;
                            DQ_OE <= 1'b1;
                            state <= S_WRITE;
                            timer <= CNT_W'(WP_CYC);
                        end else begin
                            // column rises, next cycle starts clean
                            RAS_N <= 1'b1;
                            CAS_N <= 1'b1;
                            state <= S_PRE;
                            timer <= CNT_W'(RAS_PRE_CYC);
                        end
                    end
                end
                // write low long enough to disable outputs
                S_WRITE: begin
                    if (timer_done) begin
                        RAS_N <= 1'b1;
                        CAS_N <= 1'b1;
                        state <= S_PRE;
                        timer <= CNT_W'(RAS_PRE_CYC);
                    end
                end
                S_PRE: begin
                    WE_N  <= 1'b1;
                    OE_N  <= 1'b1;
                    DQ_OE <= 1'b0;
                    if (timer_done)
                        state <= S_IDLE;
                end
                S_REF_CAS: begin
                    if (timer_done) begin
                        RAS_N <= 1'b0;
                        state <= S_REF_RAS;
                        timer <= CNT_W'(in_self_pend ? SELF_LOW_CYCLES : RAS_LOW_CYC);
                    end
                end
                S_REF_RAS: begin
                    if (timer_done) begin
                        if (in_self_pend) begin
                            state <= S_SELF;
                        end else begin
                            RAS_N <= 1'b1;
                            CAS_N <= 1'b1;
                            state <= S_PRE;
                            timer <= CNT_W'(RAS_PRE_CYC);
                            if (wake_left != '0)
                                wake_left <= wake_left - 1'b1;
                        end
                    end
                end
                S_SELF: begin
                    if (!SELF_REQ) begin
                        RAS_N <= 1'b1;
                        CAS_N <= 1'b1;
                        in_self_pend <= 1'b0;
                        state <= S_SELF_EXIT;
                        timer <= CNT_W'(SELF_EXIT_CYC);
                    end
                end
                S_SELF_EXIT: begin
                    if (timer_done)
                        state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
            if (state == S_PRE && timer_done && wake_left != '0)
                state <= S_POWERUP;
        end
    end

    assign IN_SELF = (state == S_SELF);
endmodule

// [dram_ctl_pkg.sv]
package dram_ctl_pkg;
    // clock period in picoseconds (250 MHz)
    localparam int CLK_PS = 4000;
    localparam int ROW_W  = 13;
    localparam int DQ_W   = 4;
    // times in their printed units
    localparam int POWERUP_US        = 100;
    localparam int SELF_MIN_LOW_US   = 100;
    localparam int SELF_EXIT_FAST_NS = 90;
    localparam int SELF_EXIT_SLOW_NS = 105;
    localparam int PAGE_ROW_MAX_NS   = 125000;
    localparam int REFRESH_PERIOD_MS = 64;
    localparam int REFRESH_SELF_MS   = 128;
    localparam int REFRESH_ROWS      = 4096;
    localparam int WAKE_CYCLES       = 8;
    localparam int RAS_LOW_NS        = 60;
    localparam int RAS_PRE_NS        = 40;
    localparam int RCD_NS            = 14;
    localparam int CSR_NS            = 5;
    localparam int CAC_NS            = 15;
    localparam int ROW_WRITE_NS      = 79;
    localparam int COL_WRITE_NS      = 49;
    localparam int WP_NS             = 10;
    // minimum intervals round up, maximum intervals round down
    localparam int POWERUP_CYC   = (POWERUP_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int SELF_LOW_CYC  = (SELF_MIN_LOW_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int SELF_EXIT_CYC = (SELF_EXIT_SLOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int PAGE_MAX_CYC  = (PAGE_ROW_MAX_NS * 1000) / CLK_PS;
    // per-row share worked in ns first so the product stays inside 32 bits
    localparam int REF_INT_CYC   = (REFRESH_PERIOD_MS * 1000000 / REFRESH_ROWS) * 1000 / CLK_PS;
    localparam int RAS_LOW_CYC   = (RAS_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RAS_PRE_CYC   = (RAS_PRE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RCD_CYC       = (RCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CSR_CYC       = (CSR_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CAC_CYC       = (CAC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int ROW_WRITE_CYC = (ROW_WRITE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int COL_WRITE_CYC = (COL_WRITE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WP_CYC        = (WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CNT_W = 24;
    typedef enum logic [3:0] {
        S_POWERUP = 4'h0, S_IDLE = 4'h1, S_ROW = 4'h3, S_COL = 4'h2,
        S_WRITE = 4'h6, S_PRE = 4'h7, S_REF_CAS = 4'h5, S_REF_RAS = 4'h4,
        S_SELF = 4'hc, S_SELF_EXIT = 4'hd
    } state_e;
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_RMW   = 2'h2;
endpackage

// [edo_dram_model.sv]
`timescale 1ns/1ps
module edo_dram_model
    import dram_ctl_pkg::*;
#(
    parameter int ACC_NS = 2
) (
    // strobes, active low
    input  wire logic             ras_n,
    input  wire logic             cas_n,
    input  wire logic             we_n,
    input  wire logic             oe_n,
    // address, data and refresh count
    input  wire logic [ROW_W-1:0] addr,
    input  wire logic [DQ_W-1:0]  din,
    output logic      [DQ_W-1:0]  dout,
    output int                    n_refresh
);
    logic [DQ_W-1:0]    mem [logic [2*ROW_W-1:0]];
    logic [2*ROW_W-1:0] key;
    logic [DQ_W-1:0]    rd = 4'h0;
    bit                 drv;
    initial n_refresh = 0;
    // own counter picks the row; 1 ns lets same-edge pins settle
    always @(negedge ras_n) begin
        #1;
        if (!cas_n) n_refresh++;
        else key[2*ROW_W-1:ROW_W] = addr;
    end
    // early write on column fall, read otherwise
    always @(negedge cas_n) begin
        #1;
        key[ROW_W-1:0] = addr;
        drv = ras_n ? drv : we_n;
        if (!ras_n && !we_n) mem[key] = din;
        if (!ras_n && we_n) rd = mem[key];
    end
    // late write captures, outputs stay off
    always @(negedge we_n) begin
        #1;
        if (!ras_n && !cas_n) mem[key] = din;
        drv = 0;
    end
    // a released line shows the inverse, not stale data
    assign #(ACC_NS) dout = (drv && !cas_n && !oe_n) ? rd : ~rd;
endmodule

// [edo_dram_host_sva.sv]
`timescale 1ns/1ps
module edo_dram_host_sva
    import dram_ctl_pkg::*;
#(
    parameter int POWERUP_CYCLES  = POWERUP_CYC,
    parameter int SELF_LOW_CYCLES = SELF_LOW_CYC
) (
    // clock, reset, user side
    input wire logic       CLOCK,
    input wire logic       RST,
    input wire logic       REQ_VALID,
    input wire logic       REQ_READY,
    input wire logic [1:0] REQ_OP,
    input wire logic       RDATA_VALID,
    // dram pins and self refresh flag
    input wire logic       RAS_N,
    input wire logic       CAS_N,
    input wire logic       WE_N,
    input wire logic       OE_N,
    input wire logic       DQ_OE,
    input wire logic       IN_SELF
);
    int   up, lo, hi, clo, wake;
    logic ref_cyc, long_low;
    // run lengths per strobe level; long_low marks a self refresh
    always_ff @(posedge CLOCK) begin
        up <= RST ? 0 : up + 1;
        lo <= (RST || RAS_N) ? 0 : lo + 1;
        hi <= (RST || !RAS_N) ? 0 : hi + 1;
        clo <= (RST || CAS_N) ? 0 : clo + 1;
        wake <= RST ? 0 : wake + int'($fell(RAS_N) && !CAS_N);
        ref_cyc <= RST ? 1'b0 : ($fell(RAS_N) ? !CAS_N : ref_cyc);
        long_low <= RST ? 1'b0 : (RAS_N ? long_low : ref_cyc && lo >= SELF_LOW_CYCLES);
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    a_powerup_wait: assert property ($fell(RAS_N) |-> up >= POWERUP_CYCLES)
        else $error("row strobe before power-up wait");
    a_wake_first: assert property (REQ_READY |-> wake >= WAKE_CYCLES)
        else $error("take before wake refreshes");
    a_refresh_we_high: assert property ($fell(RAS_N) && !CAS_N |-> WE_N)
        else $error("refresh with write low");
    a_row_precharge: assert property ($fell(RAS_N) |-> hi >= RAS_PRE_CYC)
        else $error("row precharge short");
    a_self_exit_pre: assert property ($fell(RAS_N) && long_low |-> hi >= SELF_EXIT_CYC)
        else $error("self refresh exit short");
    a_self_low_time: assert property ($rose(IN_SELF) |-> ref_cyc && lo >= SELF_LOW_CYCLES)
        else $error("self refresh entered too soon");
    a_row_low_max: assert property (!ref_cyc |-> lo <= PAGE_MAX_CYC)
        else $error("row low too long");
    a_rmw_we_delay: assert property ($fell(WE_N) && !CAS_N |-> lo >= ROW_WRITE_CYC && clo >= COL_WRITE_CYC)
        else $error("late write too early");
    a_read_answer: assert property (REQ_VALID && REQ_READY && REQ_OP == OP_READ |-> ##[4:20] RDATA_VALID)
        else $error("read data missing");
    a_no_contention: assert property (!CAS_N && WE_N && !OE_N |-> !DQ_OE)
        else $error("drive during read");
    c_read: cover property (REQ_VALID && REQ_READY && REQ_OP == OP_READ);
    c_rmw: cover property ($fell(WE_N) && !CAS_N);
    c_self_exit: cover property ($fell(RAS_N) && long_low);
endmodule
bind edo_dram_host edo_dram_host_sva #(.POWERUP_CYCLES(POWERUP_CYCLES), .SELF_LOW_CYCLES(SELF_LOW_CYCLES)) chk (
    .CLOCK(CLOCK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ_OP(REQ_OP),
    .RDATA_VALID(RDATA_VALID), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .OE_N(OE_N), .DQ_OE(DQ_OE),
    .IN_SELF(IN_SELF));

// [test_edo_dram_host.sv]
`timescale 1ns/1ps
module test_edo_dram_host;
    import dram_ctl_pkg::*;
    logic             clk = 0, rst = 1, valid = 0, self_req = 0, ready, rvalid, in_self;
    logic             ras_n, cas_n, we_n, oe_n, dq_oe;
    logic [1:0]       op = 0;
    logic [ROW_W-1:0] row = 0, col = 0, addr;
    logic [DQ_W-1:0]  wdata = 0, rdata, dq_out, dq_dev, dq;
    logic [DQ_W-1:0]  ref_mem [logic [25:0]];
    logic [DQ_W-1:0]  expq [$];
    logic [25:0]      keys [$];
    int               n_refresh, nr, mismatches, n_compared, cycles;
    bit               woke;
    edo_dram_host #(.POWERUP_CYCLES(20), .SELF_LOW_CYCLES(20), .REFRESH_INTERVAL(200)) DUT (
        .CLOCK(clk), .RST(rst), .REQ_VALID(valid), .REQ_READY(ready), .REQ_OP(op), .REQ_ROW(row),
        .REQ_COL(col), .REQ_WDATA(wdata), .SELF_REQ(self_req), .RDATA_VALID(rvalid), .RDATA(rdata),
        .IN_SELF(in_self), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .OE_N(oe_n), .ADDR(addr),
        .DQ_IN(dq), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
    edo_dram_model dram (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
        .din(dq), .dout(dq_dev), .n_refresh(n_refresh));
    // the shared data line follows whoever drives it
    assign dq = dq_oe ? dq_out : dq_dev;
    initial forever #2 clk = ~clk;
    task automatic check(bit ok, string msg);
        n_compared++;
        if (!ok) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // idle edge first, so valid never changes twice in one step
    task automatic req(logic [1:0] o, logic [25:0] k, logic [DQ_W-1:0] d);
        @(posedge clk);
        op <= o;
        {row, col} <= k;
        wdata <= d;
        valid <= 1;
        do @(posedge clk); while (ready !== 1'b1);
        valid <= 0;
        if (o != OP_WRITE) expq.push_back(ref_mem[k]);
        if (o != OP_READ) ref_mem[k] = d;
    endtask
    // read data checked in order; wake-up and hang watched here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (!rst && ready === 1'b1 && !woke) check(n_refresh >= WAKE_CYCLES, "early take");
        woke <= woke || ready === 1'b1;
        if (rvalid === 1'b1) check(rdata === expq.pop_front(), "read data");
        if (cycles == 8000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(90402));
        repeat (3) @(posedge clk);
        rst <= 0;
        // random early writes, read back in order
        repeat (6) keys.push_back({13'($urandom), 13'($urandom)});
        foreach (keys[i]) req(OP_WRITE, keys[i], 4'($urandom));
        foreach (keys[i]) req(OP_READ, keys[i], 4'h0);
        // read-modify-write returns the old nibble and stores the new one
        req(OP_RMW, keys[0], ~ref_mem[keys[0]]);
        req(OP_READ, keys[0], 4'h0);
        // self refresh: nothing taken inside, data kept across it
        self_req <= 1;
        for (int i = 0; i < 300 && in_self !== 1'b1; i++) @(posedge clk);
        // a pending read must stay refused while the part sleeps
        op <= OP_READ;
        {row, col} <= keys[1];
        valid <= 1;
        repeat (30) @(posedge clk);
        check(in_self === 1'b1 && ready === 1'b0, "self refresh");
        self_req <= 0;
        req(OP_READ, keys[1], 4'h0);
        // idle time still sees periodic refreshes
        nr = n_refresh;
        repeat (600) @(posedge clk);
        check(n_refresh - nr >= 2, "refresh rate");
        check(expq.size() == 0, "reads missing");
        finish_test();
    end
endmodule
